// ==== aerc_map.svh ====
// Register map, field positions, reset values and timing counts
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers
`ifndef AERC_MAP_SVH
`define AERC_MAP_SVH

`define AERC_ABE_OFFSET       4'h0
`define AERC_CRC_OFFSET       4'h4
`define AERC_ABE_RESET        8'h00
`define AERC_CRC_RESET        8'h00
`define AERC_CRC_WMASK        8'hC8
`define AERC_DTO_BIT          7
`define AERC_DSEL_HI          6
`define AERC_DSEL_LO          4
`define AERC_UVLO_BIT         3
`define AERC_VAMP_BIT         2
`define AERC_CAMP_BIT         1
`define AERC_ATO_BIT          0
`define AERC_ROLE_HI          7
`define AERC_ROLE_LO          6
`define AERC_SEMI_BIT         3
`define AERC_PULSE_NS         200
`define AERC_CLK_MHZ          200
`define AERC_PULSE_CYC        ((`AERC_PULSE_NS * `AERC_CLK_MHZ + 999) / 1000)

`endif

// ==== aerc_pkg.sv ====
// Types for the analog enable and role control block
// Assumes aerc_map.svh holds the numeric constants
package aerc_pkg;
  typedef enum logic [1:0] {
    ROLE_ALONE,
    ROLE_PRIMARY,
    ROLE_FOLLOWER,
    ROLE_SEMI
  } aerc_role_e;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } aerc_wst_e;

  typedef struct packed {
    logic [7:0] abe;
    logic [7:0] crc;
    logic       awHave;
    logic [3:0] awAddr;
    logic       wHave;
    logic [7:0] wData;
    logic       wStrb0;
    logic       bValid;
    logic [1:0] bResp;
    logic       rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    logic       pulseIn;
    logic [7:0] pulseCnt;
    logic       testBit;
  } aerc_state_s;
endpackage

// ==== aerc_ctrl.sv ====
// Analog block enable and chain role control registers with pin routing
// Assumes synchronous inputs on clk; pad logic resolves the enable signals
`timescale 1ns/10ps
`include "aerc_map.svh"

module aerc_ctrl
  import aerc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        desatCompareOut,
  input  wire logic        pwmAfterMono,
  input  wire logic        corePwm,
  input  wire logic        timer2PeriodMatch,
  input  wire logic        ovCompareOut,
  input  wire logic        switchingFreqOut,
  input  wire logic        secondaryGateDrive,
  input  wire logic        pinA0GpioOut,
  input  wire logic        pinA0GpioOe,
  input  wire logic        pinA1In,
  input  wire logic        pinA1GpioOut,
  input  wire logic        pinA1GpioOe,
  input  wire logic        pinB1GpioOut,
  input  wire logic        pinB1GpioOe,
  output logic             secondaryDrivePulse,
  output logic             pinA0Out,
  output logic             pinA0Oe,
  output logic             analogTestToPin,
  output logic             analogTestToAdc,
  output logic             pinA1Out,
  output logic             pinA1Oe,
  output logic             pinB1Out,
  output logic             pinB1Oe,
  output logic             secondRefToB1,
  output logic             pwmClockSelExt,
  output logic             pwmSyncClock,
  output logic             gateUvloHigh,
  output logic             voltageAmpEnable,
  output logic             currentAmpEnable,
  output logic             ovProtectEnable,
  output logic             ampDemandLow,
  output logic [1:0]       chainRole
);

  aerc_state_s st_q;
  aerc_state_s st_d;
  logic        dtMux;
  logic        dtValid;
  logic        wrFire;
  logic [7:0]  crcMasked;
  aerc_role_e  role;

  localparam logic [7:0] PULSE_CYC = 8'(`AERC_PULSE_CYC);

  // Digital test mux decode
  // Source select decode
  always_comb begin
    dtValid = 1'b1;
    case (st_q.abe[`AERC_DSEL_HI:`AERC_DSEL_LO])
      3'h0: dtMux = desatCompareOut;
      3'h1: dtMux = pwmAfterMono;
      3'h2: dtMux = corePwm;
      3'h3: dtMux = timer2PeriodMatch;
      3'h4: dtMux = ovCompareOut;
      3'h5: dtMux = switchingFreqOut;
      3'h6: dtMux = st_q.testBit;
      default: begin
        dtMux   = 1'b0;
        dtValid = 1'b0;
      end
    endcase
  end

  assign wrFire    = st_q.awHave && st_q.wHave && !st_q.bValid;
  assign crcMasked = st_q.wData & `AERC_CRC_WMASK;

  always_comb begin
    st_d = st_q;
    // AXI write channels, either order
    if (s_axi_awvalid && !st_q.awHave) begin
      st_d.awHave = 1'b1;
      st_d.awAddr = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && !st_q.wHave) begin
      st_d.wHave  = 1'b1;
      st_d.wData  = s_axi_wdata[7:0];
      st_d.wStrb0 = s_axi_wstrb[0];
    end
    if (wrFire) begin
      st_d.awHave = 1'b0;
      st_d.wHave  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = 2'h0;
      if (st_q.awAddr == `AERC_ABE_OFFSET) begin
        if (st_q.wStrb0) begin
          st_d.abe = st_q.wData;
        end
      end else if (st_q.awAddr == `AERC_CRC_OFFSET) begin
        if (st_q.wStrb0) begin
          st_d.crc = crcMasked;
        end
      end else begin
        st_d.bResp = 2'h2;
      end
    end
    if (st_q.bValid && s_axi_bready) begin
      st_d.bValid = 1'b0;
    end
    // AXI read
    if (s_axi_arvalid && !st_q.rValid) begin
      st_d.rValid = 1'b1;
      st_d.rResp  = 2'h0;
      if (s_axi_araddr[3:0] == `AERC_ABE_OFFSET) begin
        st_d.rData = st_q.abe;
      end else if (s_axi_araddr[3:0] == `AERC_CRC_OFFSET) begin
        st_d.rData = st_q.crc;
      end else begin
        st_d.rData = 8'h00;
        st_d.rResp = 2'h2;
      end
    end else if (st_q.rValid && s_axi_rready) begin
      st_d.rValid = 1'b0;
    end
    // 200 ns one-shot on drive rising edge
    st_d.pulseIn = secondaryGateDrive;
    if (secondaryGateDrive && !st_q.pulseIn) begin
      st_d.pulseCnt = PULSE_CYC;
      st_d.testBit  = 1'b1;
    end else if (st_q.pulseCnt > 8'h01) begin
      st_d.pulseCnt = st_q.pulseCnt - 8'h01;
    end else begin
      st_d.pulseCnt = 8'h00;
      st_d.testBit  = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q          <= '0;
      st_q.abe      <= `AERC_ABE_RESET;
      st_q.crc      <= `AERC_CRC_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign s_axi_awready = !st_q.awHave;
  assign s_axi_wready  = !st_q.wHave;
  assign s_axi_bvalid  = st_q.bValid;
  assign s_axi_bresp   = st_q.bResp;
  assign s_axi_arready = !st_q.rValid;
  assign s_axi_rvalid  = st_q.rValid;
  assign s_axi_rresp   = st_q.rResp;
  assign s_axi_rdata   = {24'h000000, st_q.rData};

  assign secondaryDrivePulse = st_q.testBit;

  // Pin A0 routing
  always_comb begin
    analogTestToPin = 1'b0;
    if (st_q.abe[`AERC_DTO_BIT]) begin
      pinA0Out = dtMux;
      pinA0Oe  = dtValid;
    end else if (st_q.abe[`AERC_ATO_BIT]) begin
      pinA0Out        = 1'b0;
      pinA0Oe         = 1'b0;
      analogTestToPin = 1'b1;
    end else begin
      pinA0Out = pinA0GpioOut;
      pinA0Oe  = pinA0GpioOe;
    end
  end
  assign analogTestToAdc = !st_q.abe[`AERC_ATO_BIT];

  assign gateUvloHigh     = st_q.abe[`AERC_UVLO_BIT];
  assign voltageAmpEnable = !st_q.abe[`AERC_VAMP_BIT];
  assign ovProtectEnable  = st_q.abe[`AERC_VAMP_BIT];
  assign currentAmpEnable = !st_q.abe[`AERC_CAMP_BIT];
  assign ampDemandLow     = st_q.abe[`AERC_VAMP_BIT] && st_q.abe[`AERC_CAMP_BIT];

  assign role      = aerc_role_e'(st_q.crc[`AERC_ROLE_HI:`AERC_ROLE_LO]);
  assign chainRole = st_q.crc[`AERC_ROLE_HI:`AERC_ROLE_LO];

  // Role pin routing
  always_comb begin
    secondRefToB1  = 1'b0;
    pwmClockSelExt = 1'b0;
    pinA1Out       = pinA1GpioOut;
    pinA1Oe        = pinA1GpioOe;
    pinB1Out       = pinB1GpioOut;
    pinB1Oe        = pinB1GpioOe;
    case (role)
      ROLE_PRIMARY: begin
        secondRefToB1 = 1'b1;
        pinB1Oe       = 1'b0;
        pinB1Out      = 1'b0;
        pinA1Out      = switchingFreqOut;
        pinA1Oe       = 1'b1;
      end
      ROLE_FOLLOWER: begin
        pwmClockSelExt = 1'b1;
        pinA1Out       = 1'b0;
        pinA1Oe        = 1'b0;
      end
      ROLE_SEMI: begin
        if (st_q.crc[`AERC_SEMI_BIT]) begin
          secondRefToB1 = 1'b1;
          pinB1Oe       = 1'b0;
          pinB1Out      = 1'b0;
        end else begin
          pinB1Oe  = 1'b1;
          pinA1Out = switchingFreqOut;
          pinA1Oe  = 1'b1;
        end
      end
      default: begin
        secondRefToB1  = 1'b0;
        pwmClockSelExt = 1'b0;
      end
    endcase
  end
  assign pwmSyncClock = pwmClockSelExt ? pinA1In : switchingFreqOut;

endmodule

// ==== aerc_ctrl_chk.sv ====
// Port checker for the control register block
// Assumes it is bound to aerc_ctrl and sees only its ports
`timescale 1ns/10ps
module aerc_ctrl_chk
  import aerc_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ampDemandLow,
  input wire logic       voltageAmpEnable,
  input wire logic       currentAmpEnable,
  input wire logic       ovProtectEnable,
  input wire logic [1:0] chainRole,
  input wire logic       secondRefToB1,
  input wire logic       pinA1Oe,
  input wire logic       pinA1Out,
  input wire logic       pinA1In,
  input wire logic       pinB1Oe,
  input wire logic       switchingFreqOut,
  input wire logic       pwmClockSelExt,
  input wire logic       pwmSyncClock,
  input wire logic       secondaryDrivePulse,
  input wire logic       analogTestToPin,
  input wire logic       pinA0Oe
);
  logic [7:0] runLen_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Length of the current one-shot
  always_ff @(posedge clk) begin
    if (!nrst) runLen_q <= 8'h00;
    else if (secondaryDrivePulse) runLen_q <= runLen_q + 8'h01;
    else runLen_q <= 8'h00;
  end
  a_demand_low: assert property (
    ampDemandLow == (!voltageAmpEnable && !currentAmpEnable)) else $error("demand flag");
  a_ovp_follows: assert property (
    ovProtectEnable != voltageAmpEnable) else $error("overvoltage enable");
  a_primary_pins: assert property (
    chainRole == ROLE_PRIMARY |-> secondRefToB1 && pinA1Oe && pinA1Out == switchingFreqOut)
    else $error("primary pins");
  a_follower_sync: assert property (
    chainRole == ROLE_FOLLOWER |-> pwmClockSelExt && pwmSyncClock == pinA1In)
    else $error("follower clock");
  a_alone_internal: assert property (
    chainRole == ROLE_ALONE |-> !secondRefToB1 && pwmSyncClock == switchingFreqOut)
    else $error("alone routing");
  a_semi_clock: assert property (
    chainRole == ROLE_SEMI && !secondRefToB1 |-> pinB1Oe && pinA1Oe) else $error("semi pins");
  a_pulse_len: assert property (
    $fell(secondaryDrivePulse) |-> runLen_q >= 8'h28) else $error("pulse short");
  a_analog_pin: assert property (
    analogTestToPin |-> !pinA0Oe) else $error("analog pin driven");
  c_semi: cover property (chainRole == ROLE_SEMI && !secondRefToB1);
  c_follow: cover property (pwmClockSelExt && pwmSyncClock);
  c_pulse: cover property ($fell(secondaryDrivePulse));
endmodule

bind aerc_ctrl aerc_ctrl_chk aerc_ctrl_chk_i (.*);

// ==== aerc_follower_model.sv ====
// Follower controller model on the sync clock and reference lines
// Assumes the bench resolves the pin A1 level
`timescale 1ns/10ps
module aerc_follower_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       syncLine,
  input  wire logic       refLine,
  output logic      [7:0] syncEdges,
  output logic            refTaken
);
  logic last_q;
  assign refTaken = refLine;
  always_ff @(posedge clk) begin
    last_q <= syncLine;
    if (!nrst) syncEdges <= 8'h00;
    else if (syncLine && !last_q) syncEdges <= syncEdges + 8'h01;
  end
endmodule

// ==== aerc_ctrl_tb_top.sv ====
// Self-checking bench for the control register block
// Assumes the design, checker and follower model are compiled first
`timescale 1ns/10ps
module aerc_ctrl_tb_top;
  logic        clk = 1'b0, nrst = 1'b0, extClk = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, chainRole;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        secondaryDrivePulse, pinA0Out, pinA0Oe, analogTestToPin, analogTestToAdc;
  logic        pinA1Out, pinA1Oe, pinB1Out, pinB1Oe, secondRefToB1, pwmClockSelExt;
  logic        pwmSyncClock, gateUvloHigh, voltageAmpEnable, currentAmpEnable;
  logic        ovProtectEnable, ampDemandLow, refTaken;
  logic [6:0]  src = 7'h00;
  logic [5:0]  gp = 6'h1A;
  logic [7:0]  syncEdges, e0;
  int          err_total = 0, n_compared = 0;
  wire desatCompareOut = src[0], pwmAfterMono = src[1], corePwm = src[2];
  wire timer2PeriodMatch = src[3], ovCompareOut = src[4], switchingFreqOut = src[5];
  wire secondaryGateDrive = src[6], pinA1In = pinA1Oe ? pinA1Out : extClk;
  wire pinA0GpioOut = gp[5], pinA0GpioOe = gp[4], pinA1GpioOut = gp[3];
  wire pinA1GpioOe = gp[2], pinB1GpioOut = gp[1], pinB1GpioOe = gp[0];
  wire [4:0] ampBits = {gateUvloHigh, voltageAmpEnable, currentAmpEnable, ovProtectEnable,
                        ampDemandLow};
  wire [3:0] a0Bits = {pinA0Oe, pinA0Out & pinA0Oe, analogTestToPin, analogTestToAdc};
  wire [5:0] roleBits = {chainRole, secondRefToB1, pwmClockSelExt, pinA1Oe, pinB1Oe};

  aerc_ctrl aerc_ctrl_i (.*);
  aerc_follower_model aerc_follower_model_i (.clk(clk), .nrst(nrst), .syncLine(pinA1In),
    .refLine(secondRefToB1), .syncEdges(syncEdges), .refTaken(refTaken));

  initial forever #2.5 clk = ~clk;

  task automatic report_and_stop();
    $display("Compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 60) begin
      err_total++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 60);
    s_axi_bready <= 1'b0;
    guard(n);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 60);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
    guard(n);
  endtask

  task automatic t_reset();
    rd(32'h0, 32'h0, 2'h0);
    rd(32'h4, 32'h0, 2'h0);
    rd(32'h8, 32'h0, 2'h2);
    wr(32'h4, 32'hFF);
    rd(32'h4, 32'hC8, 2'h0);
  endtask
  task automatic t_digital();
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      src <= 7'h01 << s;
      wr(32'h80 | (s << 4), 32'h0);
      wr(32'h0, 32'h80 | (s << 4));
      settle();
      chk({pinA0Oe, pinA0Out & (s != 7)}, (s == 7) ? 32'h0 : 32'h3);
    end
  endtask
  task automatic t_pulse();
    int n;
    int len;
    @(posedge clk);
    src <= 7'h00;
    repeat (50) @(posedge clk);
    src <= 7'h40;
    n = 0;
    len = 0;
    while (!secondaryDrivePulse && n < 60) begin
      @(negedge clk);
      n++;
    end
    while (secondaryDrivePulse && len < 60) begin
      @(negedge clk);
      len++;
    end
    chk(len, 40);
    guard(n);
  endtask
  task automatic t_table(input logic [7:0] a, input logic [7:0] v [5], input logic [7:0] e [5],
                         input int cnt);
    for (int i = 0; i < cnt; i++) begin
      wr({24'h0, a}, {24'h0, v[i]});
      settle();
      if (a == 8'h4) chk(roleBits, e[i]);
      else if (cnt == 2) chk(ampBits, e[i]);
      else chk(a0Bits, e[i]);
    end
  endtask
  task automatic t_link();
    wr(32'h4, 32'h40);
    e0 = syncEdges;
    repeat (3) begin
      @(posedge clk);
      src[5] <= 1'b1;
      @(posedge clk);
      src[5] <= 1'b0;
    end
    settle();
    chk(syncEdges - e0, 32'h3);
    chk(refTaken, 32'h1);
    chk({pinB1Out, pinA1Out}, 32'h0);
    wr(32'h4, 32'h80);
    @(posedge clk);
    extClk <= 1'b1;
    settle();
    chk(pwmSyncClock, 32'h1);
    wr(32'h4, 32'hC0);
    settle();
    chk({pinB1Out, pinA1Out}, 32'h2);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_digital();
    t_pulse();
    t_table(8'h0, '{8'h0E, 8'h04, 8'h0, 8'h0, 8'h0}, '{8'h13, 8'h06, 8'h0, 8'h0, 8'h0}, 2);
    t_table(8'h0, '{8'h81, 8'h01, 8'h00, 8'h0, 8'h0}, '{8'h8, 8'h2, 8'h9, 8'h0, 8'h0}, 3);
    t_table(8'h4, '{8'h00, 8'h40, 8'h80, 8'hC0, 8'hC8}, '{8'h00, 8'h1A, 8'h24, 8'h33, 8'h38}, 5);
    t_link();
    report_and_stop();
  end
endmodule
